// ---- design/adc_measurement_scheduler.sv ----
// Notes on behaviour
// (R1) frame repeats every 1 ms or 10 ms
// (R2) channels 0-4, 8-10 selectable; 5 reserved
// (R3) go bit starts one 10-bit manual conversion
// (R4) manual done: power down, clear go, flag
// (R5) done-flag mask suppresses interrupt request
// (R6) frame starts with ten scheduled 100 us slots
// (R7) one measurement per slot, fixed slot order
// (R8) disabled automatic slots serve manual conversions
// (R9) automatic results keep eight upper bits
// (R10) supply state changes after three disagreeing readings
// (R11) supply flag on both state edges
// (R12) raised supply event pauses supply measurement
// (R13) power-good pin shows debounced supply state
// (R14) supply measured only when auto-enabled
// (R15) aux1 stored, flagged outside low/high limits
// (R16) raised aux1 event pauses; mask disables pause
// (R17) aux1 debounce needs two hits same limit
// (R18) aux1 measured only when auto-enabled
// (R19) aux1 source enable and level up to 40 uA
// (R20) aux1 source off after conversion, on early
// (R21) aux2/aux3 like aux1; aux2 source static
// (R22) sequencing paced by 2.0 MHz core tick
// (R23) manual waits for a free slot
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "adc_sched_regs.svh"

module adc_measurement_scheduler #(
   parameter int CORE_DIV   = `CORE_DIV,
   parameter int SLOT_TICKS = `SLOT_TICKS
) (
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire adc_sched_pkg::axi_req_s  axi_req,
   output      adc_sched_pkg::axi_rsp_s  axi_rsp,
   input  wire adc_sched_pkg::conv_res_s conv_res,
   output      adc_sched_pkg::conv_ctl_s conv_ctl,
   output      logic                     aux1_source_on,
   output      logic [5:0]               aux1_source_level,
   output      logic                     aux2_source_on,
   output      logic                     power_good_output,
   output      logic                     interrupt_request_n
);
   import adc_sched_pkg::*;

   // =======================================================================
   // decode helpers
   function automatic logic known_addr(input logic [7:0] a);
      case (a)
         `ADDR_CTRL, `ADDR_AUTO, `ADDR_FLAGS, `ADDR_MASK, `ADDR_RES_UPPER,
         `ADDR_RES_LOWER, `ADDR_SUPPLY, `ADDR_AUX_CFG, `ADDR_LIMIT1,
         `ADDR_LIMIT2, `ADDR_LIMIT3, `ADDR_GROUPS: known_addr = 1'b1;
         default: known_addr = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      merge = m;
   endfunction

   // fixed slot pattern: supply, g8, M, aux1, g9, M, aux2, g10, M, aux3
   function automatic logic [3:0] slot_channel(input logic [3:0] s);
      case (s)
         4'h0:    slot_channel = 4'h0;
         4'h1:    slot_channel = 4'h8;
         4'h3:    slot_channel = 4'h1;
         4'h4:    slot_channel = 4'h9;
         4'h6:    slot_channel = 4'h2;
         4'h7:    slot_channel = 4'ha;
         4'h9:    slot_channel = 4'h3;
         default: slot_channel = 4'h0;
      endcase
   endfunction

   // =======================================================================
   // registers
   logic        go;
   logic [5:0]  ctrl_cfg;
   logic [6:0]  auto_en;
   logic [4:0]  flags;
   logic [4:0]  mask;
   logic [7:0]  result_upper;
   logic [1:0]  result_lower;
   logic [7:0]  supply_threshold;
   logic [7:0]  supply_result;
   logic        supply_ok;
   logic [1:0]  supply_deb;
   logic [10:0] aux_cfg;
   logic [7:0]  low_limit  [3];
   logic [7:0]  high_limit [3];
   logic [7:0]  aux_result [3];
   logic [7:0]  group_result [3];

   wire [3:0] chan_select  = ctrl_cfg[3:0];
   wire       economy      = ctrl_cfg[`CTRL_ECO_BIT - `CTRL_CHAN_LSB];
   wire       pin12_select = ctrl_cfg[`CTRL_PIN12_BIT - `CTRL_CHAN_LSB];

   // =======================================================================
   // bus slave
   logic        aw_got;
   logic        w_got;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        awready;
   logic        wready;
   logic        bvalid;
   logic [1:0]  bresp;
   logic        arready;
   logic        rvalid;
   logic [31:0] rdata;
   logic [1:0]  rresp;

   wire wr_fire      = aw_got & w_got & ~bvalid;
   wire next_aw_got  = aw_got ? ~wr_fire : (axi_req.awvalid & awready);
   wire next_w_got   = w_got ? ~wr_fire : (axi_req.wvalid & wready);
   wire next_bvalid  = bvalid ? ~axi_req.bready : wr_fire;
   wire ar_fire      = axi_req.arvalid & arready;
   wire next_rvalid  = rvalid ? ~axi_req.rready : ar_fire;

   wire [31:0] ctrl_word   = {22'h0, ctrl_cfg, 3'h0, go};
   wire [31:0] supply_word = {15'h0, supply_ok, supply_result, supply_threshold};

   function automatic logic [31:0] read_word(input logic [7:0] a);
      case (a)
         `ADDR_CTRL:      read_word = ctrl_word;
         `ADDR_AUTO:      read_word = {25'h0, auto_en};
         `ADDR_FLAGS:     read_word = {27'h0, flags};
         `ADDR_MASK:      read_word = {27'h0, mask};
         `ADDR_RES_UPPER: read_word = {24'h0, result_upper};
         `ADDR_RES_LOWER: read_word = {30'h0, result_lower};
         `ADDR_SUPPLY:    read_word = supply_word;
         `ADDR_AUX_CFG:   read_word = {21'h0, aux_cfg};
         `ADDR_LIMIT1:    read_word = {8'h0, aux_result[0], high_limit[0], low_limit[0]};
         `ADDR_LIMIT2:    read_word = {8'h0, aux_result[1], high_limit[1], low_limit[1]};
         `ADDR_LIMIT3:    read_word = {8'h0, aux_result[2], high_limit[2], low_limit[2]};
         `ADDR_GROUPS:    read_word = {8'h0, group_result[2], group_result[1],
                                       group_result[0]};
         default:         read_word = 32'h0;
      endcase
   endfunction

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0;
         w_strb  <= 4'h0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
      end else begin
         aw_got  <= next_aw_got;
         w_got   <= next_w_got;
         awready <= ~next_aw_got & ~next_bvalid;
         wready  <= ~next_w_got & ~next_bvalid;
         bvalid  <= next_bvalid;
         if (axi_req.awvalid & awready) begin
            aw_addr <= axi_req.awaddr[7:0];
         end
         if (axi_req.wvalid & wready) begin
            w_data <= axi_req.wdata;
            w_strb <= axi_req.wstrb;
         end
         if (wr_fire) begin
            bresp <= known_addr(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= `RESP_OKAY;
      end else begin
         arready <= ~next_rvalid;
         rvalid  <= next_rvalid;
         if (ar_fire) begin
            rdata <= read_word(axi_req.araddr[7:0]);
            rresp <= known_addr(axi_req.araddr[7:0]) ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   assign axi_rsp = '{awready: awready, wready: wready, bvalid: bvalid, bresp: bresp,
                      arready: arready, rvalid: rvalid, rdata: rdata, rresp: rresp};

   // =======================================================================
   // register writes
   wire [31:0] wr_word = merge(read_word(aw_addr), w_data, w_strb);
   wire wr_ctrl   = wr_fire && aw_addr == `ADDR_CTRL;
   wire wr_flags  = wr_fire && aw_addr == `ADDR_FLAGS;
   wire [4:0] flag_clear = wr_flags ? (w_data[4:0] & {5{w_strb[0]}}) : 5'h00;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_cfg         <= 6'(`RST_CTRL >> `CTRL_CHAN_LSB);
         auto_en          <= `RST_AUTO;
         mask             <= `RST_MASK;
         supply_threshold <= `RST_THRESHOLD;
         aux_cfg          <= `RST_AUX_CFG;
      end else if (wr_fire) begin
         case (aw_addr)
            `ADDR_CTRL:    ctrl_cfg         <= wr_word[9:4];
            `ADDR_AUTO:    auto_en          <= wr_word[6:0];
            `ADDR_MASK:    mask             <= wr_word[4:0];
            `ADDR_SUPPLY:  supply_threshold <= wr_word[7:0];
            `ADDR_AUX_CFG: aux_cfg          <= wr_word[10:0];
            default:       ;
         endcase
      end
   end

   // =======================================================================
   // 2 MHz core tick, slot and frame counters
   logic [7:0] div_cnt;
   logic [7:0] tick_cnt;
   logic [6:0] slot_num;
   logic       slot_begin;
   logic       core_tick;

   wire slot_wrap  = core_tick && tick_cnt == 8'(SLOT_TICKS - 1);
   wire [6:0] frame_last = economy ? 7'(`FRAME_ECO_SLOTS - 1)
                                   : 7'(`FRAME_FAST_SLOTS - 1); // R1

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt    <= 8'h00;
         core_tick  <= 1'b0;
         tick_cnt   <= 8'h00;
         slot_num   <= 7'h00;
         slot_begin <= 1'b0;
      end else begin
         core_tick  <= div_cnt == 8'(CORE_DIV - 1);                  // R22
         div_cnt    <= (div_cnt == 8'(CORE_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
         slot_begin <= slot_wrap;
         if (core_tick) begin
            tick_cnt <= slot_wrap ? 8'h00 : tick_cnt + 8'h01;        // R6
         end
         if (slot_wrap) begin
            slot_num <= (slot_num >= frame_last) ? 7'h00 : slot_num + 7'h01;
         end
      end
   end

   // =======================================================================
   // slot arbitration
   wire       supply_pause = flags[`FLAG_SUPPLY] & ~mask[`FLAG_SUPPLY];          // R12
   wire [2:0] aux_pause    = flags[`FLAG_AUX_LSB +: 3] & ~mask[`FLAG_AUX_LSB +: 3]; // R16
   wire [2:0] aux_run      = auto_en[3:1] & ~aux_pause;                          // R18
   wire [9:0] auto_want    = {aux_run[2], 1'b0, auto_en[6], aux_run[1], 1'b0,
                              auto_en[5], aux_run[0], 1'b0, auto_en[4],
                              auto_en[0] & ~supply_pause};                       // R14
   wire       in_frame     = slot_num < 7'(`SCHED_SLOTS);
   wire [3:0] slot_idx     = slot_num[3:0];
   wire       auto_slot    = in_frame && auto_want[slot_idx];                    // R7
   wire       man_ok       = go && !auto_slot;                                   // R8 R23

   conv_state_e state;
   conv_state_e next_state;
   logic [3:0]  cur_slot;
   logic [3:0]  cur_chan;
   logic        start_q;

   wire chan_legal = chan_select <= 4'h4 || (chan_select >= 4'h8 && chan_select <= 4'ha);
   wire launch_auto = state == CONV_IDLE && slot_begin && auto_slot;
   wire launch_man  = state == CONV_IDLE && slot_begin && man_ok;
   wire auto_done   = state == CONV_AUTO && conv_res.done;
   wire man_done    = state == CONV_MAN && conv_res.done;
   wire [7:0] reading = conv_res.data[9:2];                                      // R9

   always_comb begin
      next_state = state;
      case (state)
         CONV_IDLE: begin
            if (launch_auto) begin
               next_state = CONV_AUTO;
            end else if (launch_man) begin
               next_state = CONV_MAN;
            end
         end
         CONV_AUTO: begin
            if (conv_res.done) begin
               next_state = CONV_IDLE;
            end
         end
         CONV_MAN: begin
            if (conv_res.done) begin
               next_state = CONV_IDLE;                                           // R4
            end
         end
         default: next_state = CONV_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state    <= CONV_IDLE;
         cur_slot <= 4'h0;
         cur_chan <= 4'h0;
         start_q  <= 1'b0;
      end else begin
         state   <= next_state;
         start_q <= launch_auto | launch_man;
         if (launch_auto) begin
            cur_slot <= slot_idx;
            cur_chan <= slot_channel(slot_idx);                                  // R2
         end else if (launch_man) begin
            cur_chan <= chan_legal ? chan_select : 4'h0;                         // R2 R3
         end
      end
   end

   // powered only while converting
   assign conv_ctl = '{power: state != CONV_IDLE, start: start_q, channel: cur_chan};

   // =======================================================================
   // manual results and go bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         go           <= 1'b0;
         result_upper <= 8'h00;
         result_lower <= 2'h0;
      end else begin
         if (wr_ctrl && wr_word[`CTRL_GO_BIT]) begin
            go <= 1'b1;
         end else if (man_done) begin
            go <= 1'b0;                                                          // R4
         end
         if (man_done) begin
            result_upper <= conv_res.data[9:2];                                  // R3
            result_lower <= conv_res.data[1:0];
         end
      end
   end

   // =======================================================================
   // supply supervision
   wire supply_done = auto_done && cur_slot == 4'h0;
   wire supply_hi   = reading >= supply_threshold;
   wire supply_flip = supply_done && supply_hi != supply_ok &&
                      supply_deb == 2'(`SUPPLY_DEB_COUNT - 1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         supply_result <= 8'h00;
         supply_ok     <= 1'b0;
         supply_deb    <= 2'h0;
      end else if (supply_done) begin
         supply_result <= reading;
         if (supply_hi == supply_ok) begin
            supply_deb <= 2'h0;                                                  // R10
         end else if (supply_flip) begin
            supply_ok  <= supply_hi;
            supply_deb <= 2'h0;
         end else begin
            supply_deb <= supply_deb + 2'h1;
         end
      end
   end

   // =======================================================================
   // aux channels and regulator groups
   logic [2:0] aux_set;
   logic       src1_dyn;
   wire        src1_hold = src1_dyn & ~(auto_done && cur_slot == 4'h3);

   for (genvar i = 0; i < 3; i++) begin : g_aux
      logic prev_lo;
      logic prev_hi;
      wire  done_i = auto_done && cur_slot == 4'(3 + 3 * i);
      wire  lo     = reading < low_limit[i];
      wire  hi     = reading > high_limit[i];
      wire  deb    = aux_cfg[`AUX_DEB_LSB + i];
      wire  wr_lim = wr_fire && aw_addr == 8'(`ADDR_LIMIT1 + 4 * i);
      wire  gdone  = auto_done && cur_slot == 4'(1 + 3 * i);

      assign aux_set[i] = done_i && (deb ? ((lo && prev_lo) || (hi && prev_hi))
                                         : (lo || hi));                          // R15 R17 R21

      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            prev_lo         <= 1'b0;
            prev_hi         <= 1'b0;
            aux_result[i]   <= 8'h00;
            group_result[i] <= 8'h00;
            low_limit[i]    <= `RST_LOW_LIMIT;
            high_limit[i]   <= `RST_HIGH_LIMIT;
         end else begin
            if (done_i) begin
               aux_result[i] <= reading;                                         // R15
               prev_lo       <= lo;
               prev_hi       <= hi;
            end
            if (gdone) begin
               group_result[i] <= reading;
            end
            if (wr_lim) begin
               low_limit[i]  <= wr_word[7:0];
               high_limit[i] <= wr_word[15:8];
            end
         end
      end
   end

   // =======================================================================
   // flags, current sources and pins
   wire [4:0] flag_set = {aux_set, supply_flip, man_done};                       // R4 R11

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags               <= 5'h00;
         src1_dyn            <= 1'b0;
         aux1_source_on      <= 1'b0;
         aux1_source_level   <= 6'h00;
         aux2_source_on      <= 1'b0;
         power_good_output   <= 1'b0;
         interrupt_request_n <= 1'b1;
      end else begin
         // a same-cycle event beats the clear
         flags <= (flags & ~flag_clear) | flag_set;
         if (auto_done && cur_slot == 4'h3) begin
            src1_dyn <= 1'b0;                                                    // R20
         end else if (slot_begin && in_frame && slot_idx == 4'h2) begin
            src1_dyn <= 1'b1;                                                    // R20
         end
         // static unless aux1 auto runs
         aux1_source_on      <= aux_cfg[`AUX_SRC1_EN_BIT] & (src1_hold | ~aux_run[0]); // R20
         aux1_source_level   <= aux_cfg[`AUX_LEVEL_LSB +: 6];                   // R19
         aux2_source_on      <= aux_cfg[`AUX_SRC2_EN_BIT];                      // R21
         power_good_output   <= pin12_select & supply_ok;                       // R13
         interrupt_request_n <= ~|(flags & ~mask);                              // R5
      end
   end

endmodule

// ---- design/adc_sched_pkg.sv ----
package adc_sched_pkg;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_s;

   typedef struct packed {
      logic       power;
      logic       start;
      logic [3:0] channel;
   } conv_ctl_s;

   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } conv_res_s;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_AUTO = 2'b01,
      CONV_MAN  = 2'b10
   } conv_state_e;

endpackage

// ---- design/adc_sched_regs.svh ----
`ifndef ADC_SCHED_REGS_SVH
`define ADC_SCHED_REGS_SVH

// ==========================================================================
// timing
`define CLK_HZ            250000000
`define CORE_HZ           2000000
`define CORE_DIV          (`CLK_HZ / `CORE_HZ)
`define SLOT_US           100
`define SLOT_TICKS        (`SLOT_US * (`CORE_HZ / 1000000))
`define FRAME_FAST_US     1000
`define FRAME_ECO_US      10000
`define FRAME_FAST_SLOTS  (`FRAME_FAST_US / `SLOT_US)
`define FRAME_ECO_SLOTS   (`FRAME_ECO_US / `SLOT_US)
`define SCHED_SLOTS       10
`define SUPPLY_DEB_COUNT  3

// ==========================================================================
// register offsets (byte addresses)
`define ADDR_CTRL         8'h00
`define ADDR_AUTO         8'h04
`define ADDR_FLAGS        8'h08
`define ADDR_MASK         8'h0c
`define ADDR_RES_UPPER    8'h10
`define ADDR_RES_LOWER    8'h14
`define ADDR_SUPPLY       8'h18
`define ADDR_AUX_CFG      8'h1c
`define ADDR_LIMIT1       8'h20
`define ADDR_LIMIT2       8'h24
`define ADDR_LIMIT3       8'h28
`define ADDR_GROUPS       8'h2c

// ==========================================================================
// field positions
`define CTRL_GO_BIT       0
`define CTRL_CHAN_LSB     4
`define CTRL_ECO_BIT      8
`define CTRL_PIN12_BIT    9
`define AUX_SRC1_EN_BIT   0
`define AUX_LEVEL_LSB     1
`define AUX_SRC2_EN_BIT   7
`define AUX_DEB_LSB       8
`define FLAG_DONE         0
`define FLAG_SUPPLY       1
`define FLAG_AUX_LSB      2

// ==========================================================================
// reset values
`define RST_CTRL          32'h0000_0000
`define RST_AUTO          7'h00
`define RST_MASK          5'h00
`define RST_THRESHOLD     8'h00
`define RST_AUX_CFG       11'h000
`define RST_LOW_LIMIT     8'h00
`define RST_HIGH_LIMIT    8'hff
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- tb/adc_sched_sva.sv ----
`timescale 1ns/1ns
// ========
// converter link checks
module adc_sched_sva #(
   parameter int CORE_DIV   = 2,
   parameter int SLOT_TICKS = 8
) (
   input wire logic                     clk,
   input wire logic                     rst_b,
   input wire adc_sched_pkg::conv_res_s conv_res,
   input wire adc_sched_pkg::conv_ctl_s conv_ctl,
   input wire logic                     aux1_source_on,
   input wire logic                     aux2_source_on
);
   import adc_sched_pkg::*;
   localparam int SLOT_CLKS = CORE_DIV * SLOT_TICKS;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   int   gap;
   logic seen;
   // launches sit on slot edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap  <= 0;
         seen <= 1'b0;
      end else begin
         gap  <= conv_ctl.start ? 1 : gap + 1;
         seen <= seen | conv_ctl.start;
      end
   end
   sequence conv_end;
      conv_res.done && conv_ctl.power;
   endsequence
   AST_START_PULSE: assert property (conv_ctl.start |=> !conv_ctl.start)
      else $error("start pulse too long");
   AST_START_POWER: assert property ($rose(conv_ctl.start) |-> conv_ctl.power)
      else $error("start without power");
   AST_POWER_DOWN: assert property (conv_end |=> !conv_ctl.power)
      else $error("power kept after done");
   AST_CHAN_STABLE: assert property (conv_ctl.power && !conv_ctl.start |-> $stable(conv_ctl.channel))
      else $error("channel moved in conversion");
   AST_CHAN_LEGAL: assert property (conv_ctl.start |-> conv_ctl.channel inside {[0:4], [8:10]})
      else $error("illegal channel launched");
   AST_SLOT_GAP: assert property (conv_ctl.start && seen |-> gap % SLOT_CLKS == 0)
      else $error("launch off slot edge");
   AST_AUX1_OFF: assert property (conv_end ##0 conv_ctl.channel == 4'h1 |=> !aux1_source_on)
      else $error("aux1 source left on");
   AST_AUX2_STATIC: assert property (conv_end |=> $stable(aux2_source_on))
      else $error("aux2 source switched");
endmodule
bind adc_measurement_scheduler adc_sched_sva #(
   .CORE_DIV  (CORE_DIV),
   .SLOT_TICKS(SLOT_TICKS)
) chk (
   .clk           (clk),
   .rst_b         (rst_b),
   .conv_res      (conv_res),
   .conv_ctl      (conv_ctl),
   .aux1_source_on(aux1_source_on),
   .aux2_source_on(aux2_source_on)
);

// ---- tb/conv_model.sv ----
`timescale 1ns/1ns
// ========
// converter model
module conv_model (
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire adc_sched_pkg::conv_ctl_s conv_ctl,
   input  wire logic [9:0]               vin [0:10],
   input  wire logic                     slow,
   output      adc_sched_pkg::conv_res_s conv_res
);
   import adc_sched_pkg::*;
   int left;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_res <= '0;
         left     <= 0;
      end else begin
         // data is junk outside the done cycle
         conv_res.done <= 1'b0;
         conv_res.data <= ~conv_res.data;
         if (conv_ctl.start)
            left <= slow ? 10 : 2;
         else if (left != 0)
            left <= left - 1;
         if (left == 1 && conv_ctl.power) begin
            conv_res.done <= 1'b1;
            conv_res.data <= vin[conv_ctl.channel];
         end
      end
   end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`include "adc_sched_regs.svh"
// ========
// bench
module tb;
   import adc_sched_pkg::*;
   localparam logic [3:0] CHANS [0:7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha};
   logic        clk, rst_b, slow, a1_on, a2_on, pg, irq_n;
   logic [5:0]  a1_lvl;
   logic [9:0]  vin [0:10];
   logic [31:0] rd;
   logic [1:0]  rr;
   axi_req_s    req;
   axi_rsp_s    rsp;
   conv_res_s   cres;
   conv_ctl_s   cctl;
   int          mismatches, num_checks;
   adc_measurement_scheduler #(.CORE_DIV(2), .SLOT_TICKS(8)) uut (.clk(clk), .rst_b(rst_b),
      .axi_req(req), .axi_rsp(rsp), .conv_res(cres), .conv_ctl(cctl), .aux1_source_on(a1_on),
      .aux1_source_level(a1_lvl), .aux2_source_on(a2_on), .power_good_output(pg),
      .interrupt_request_n(irq_n));
   conv_model far (.clk(clk), .rst_b(rst_b), .conv_ctl(cctl), .vin(vin), .slow(slow),
      .conv_res(cres));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req.awaddr <= {24'h0, a};
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.awready === 1'b1)
            req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1)
            req.wvalid <= 1'b0;
      end while (req.awvalid || req.wvalid);
      while (rsp.bvalid !== 1'b1) @(posedge clk);
      req.bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      req.araddr <= {24'h0, a};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do @(posedge clk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge clk); while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task automatic wait_flag(input int b, output int c);
      int t0;
      t0 = int'($time / 4);
      rdr(`ADDR_FLAGS);
      for (int i = 0; i < 2000 && rd[b] !== 1'b1; i++) rdr(`ADDR_FLAGS);
      c = int'($time / 4) - t0;
   endtask
   // third reading two to three frames on
   function automatic logic in_win(input int c, input int f);
      return c >= 2 * f - 8 && c <= 3 * f + 60;
   endfunction
   initial begin
      #(4 * 40000);
      mismatches++;
      print_verdict();
   end
   initial begin
      logic [9:0] v;
      logic [3:0] ch;
      logic       m;
      logic [5:0] lvl;
      int         c;
      rst_b = 1'b0;
      req = '0;
      slow = 1'b0;
      vin = '{default: 10'h0};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      void'($urandom(70));
      rdr(`ADDR_LIMIT1);
      check(rd, 32'h0000_ff00);
      rdr(8'h30);
      check({rd[29:0], rr}, 32'h2);
      for (int i = 0; i < 8; i++) begin
         ch = CHANS[i];
         v = 10'($urandom);
         m = 1'($urandom);
         slow <= 1'($urandom);
         vin[ch == 4'h5 ? 4'h0 : ch] <= v;
         wr(`ADDR_MASK, {31'h0, m});
         wr(`ADDR_CTRL, {24'h0, ch, 4'h1});
         wait_flag(0, c);
         rdr(`ADDR_RES_UPPER);
         check(rd, {24'h0, v[9:2]});
         rdr(`ADDR_RES_LOWER);
         check(rd, {30'h0, v[1:0]});
         rdr(`ADDR_FLAGS);
         check({rd[30:0], irq_n}, {31'h1, m});
         wr(`ADDR_FLAGS, 32'h1);
      end
      lvl = 6'($urandom);
      vin[1] <= 10'h200;
      wr(`ADDR_LIMIT1, 32'h0000_c040);
      wr(`ADDR_AUX_CFG, {24'h0, 1'b1, lvl, 1'b1});
      wr(`ADDR_AUTO, 32'h2);
      repeat (400) @(posedge clk);
      rdr(`ADDR_LIMIT1);
      check({rd[23:0], a2_on, 1'b0, a1_lvl}, {24'h80_c040, 2'h2, lvl});
      vin[1] <= 10'h3fd;
      wait_flag(2, c);
      check({rd[2], irq_n}, 2'h2);
      vin[1] <= 10'h100;
      repeat (400) @(posedge clk);
      rdr(`ADDR_LIMIT1);
      check(rd, 32'h00ff_c040);
      wr(`ADDR_FLAGS, 32'h4);
      repeat (400) @(posedge clk);
      rdr(`ADDR_LIMIT1);
      check(rd, 32'h0040_c040);
      wr(`ADDR_AUTO, 32'h0);
      wr(`ADDR_SUPPLY, 32'h80);
      wr(`ADDR_CTRL, 32'h200);
      vin[0] <= 10'h300;
      wr(`ADDR_AUTO, 32'h1);
      wait_flag(1, c);
      check(in_win(c, 160), 1'b1);
      vin[0] <= 10'h004;
      repeat (400) @(posedge clk);
      rdr(`ADDR_SUPPLY);
      check({rd[29:0], pg, irq_n}, {30'h1_c080, 2'h2});
      wr(`ADDR_CTRL, 32'h300);
      wr(`ADDR_FLAGS, 32'h2);
      wait_flag(1, c);
      check(in_win(c, 1600), 1'b1);
      rdr(`ADDR_SUPPLY);
      check({rd[30:0], pg}, 32'h0000_0300);
      print_verdict();
   end
endmodule
